// *** common/fpu_decode_cfg.svh ***
// Encodings, reset values and cycle counts of the control and
// transcendental decoder. Included by the decoder and its package users.
`ifndef FPU_DECODE_CFG_SVH
`define FPU_DECODE_CFG_SVH

// Escape byte: upper five bits, group in the low three
`define COPROC_ESCAPE_TAG      5'h1b
`define GROUP_001              3'h1
`define GROUP_011              3'h3
`define GROUP_101              3'h5
`define GROUP_111              3'h7

// Register-form second bytes
`define BYTE_COSINE            8'hff
`define BYTE_PART_TANGENT      8'hf2
`define BYTE_PART_ARCTANGENT   8'hf3
`define BYTE_SINE              8'hfe
`define BYTE_SINE_COSINE       8'hfb
`define BYTE_LOG_PLUS_ONE      8'hf9
`define BYTE_REINITIALIZE      8'he3
`define BYTE_STATUS_TO_HOST    8'he0
`define BYTE_CLEAR_EXCEPTIONS  8'he2
`define BYTE_STACK_INC         8'hf7
`define BYTE_STACK_DEC         8'hf6
`define BYTE_NO_OPERATION      8'hd0
`define BYTE_LEGACY_INT_EN     8'he0
`define BYTE_LEGACY_INT_DIS    8'he1

// Memory-form reg field values
`define REG_LOAD_CONTROL       3'h5
`define REG_STORE_STATUS       3'h7
`define REG_STORE_ENV          3'h6
`define REG_LOAD_ENV           3'h4
`define REG_SAVE_STATE         3'h6
`define REG_RESTORE_STATE      3'h4
`define MOD_REGISTER_FORM      2'h3

// Cycle counts, least and most
`define CYC_COSINE_MIN         10'd123
`define CYC_COSINE_MAX         10'd772
`define CYC_TANGENT_MIN        10'd191
`define CYC_TANGENT_MAX        10'd497
`define CYC_ARCTAN_MIN         10'd314
`define CYC_ARCTAN_MAX         10'd487
`define CYC_SINE_MIN           10'd122
`define CYC_SINE_MAX           10'd771
`define CYC_SINCOS_MIN         10'd194
`define CYC_SINCOS_MAX         10'd809
`define CYC_LOGP1_MIN          10'd257
`define CYC_LOGP1_MAX          10'd547
`define CYC_REDUCTION          10'd76
`define CYC_REINITIALIZE       10'd33
`define CYC_STATUS_TO_HOST     10'd13
`define CYC_LOAD_CONTROL       10'd19
`define CYC_STORE_STATUS       10'd15
`define CYC_CLEAR_EXCEPTIONS   10'd11
`define CYC_STORE_ENV_MIN      10'd103
`define CYC_STORE_ENV_MAX      10'd104
`define CYC_LOAD_ENV           10'd71
`define CYC_SAVE_STATE_MIN     10'd375
`define CYC_SAVE_STATE_MAX     10'd376
`define CYC_RESTORE_STATE      10'd308
`define CYC_STACK_INC          10'd21
`define CYC_STACK_DEC          10'd22
`define CYC_NO_OPERATION       10'd12

// Reset values
`define RESET_CONTROL_WORD     16'h003f
`define RESET_STACK_PTR        3'h0
`define RESET_EXC_FLAGS        6'h00

`endif

// *** common/fpu_decode_pkg.sv ***
// Types used by the decoder; its cycle timer uses none of them.
// Assumes the constants header sits beside it.
package fpu_decode_pkg;
    typedef enum logic [4:0] {
        OP_NONE,
        OP_COSINE,
        OP_PARTIAL_TANGENT,
        OP_PARTIAL_ARCTANGENT,
        OP_SINE,
        OP_SINE_COSINE,
        OP_SCALED_LOG_PLUS_ONE,
        OP_REINITIALIZE,
        OP_STORE_STATUS_WORD_HOST,
        OP_LOAD_CONTROL_WORD,
        OP_STORE_STATUS_WORD_MEM,
        OP_CLEAR_EXCEPTIONS,
        OP_STORE_ENVIRONMENT,
        OP_LOAD_ENVIRONMENT,
        OP_SAVE_FULL_STATE,
        OP_RESTORE_FULL_STATE,
        OP_STACK_PTR_INCREMENT,
        OP_STACK_PTR_DECREMENT,
        OP_NO_OPERATION
    } op_type;

    typedef enum logic {
        ST_IDLE,
        ST_EXECUTE
    } state_type;
endpackage

// *** verilog/op_cycle_timer.sv ***
// Down counter that times one instruction's execution.
// Assumes a single clock and a synchronous active-high reset.
module op_cycle_timer #(
    parameter int W = 10
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic         start,
    input  wire logic [W-1:0] startCount,
    output logic              running,
    output logic              done
);
    logic [W-1:0] count;
    wire          lastCycle = running && (count <= W'(1));

    // Load on start, count down, pulse done on the last cycle
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            count   <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end
        else if (start)
        begin
            count   <= startCount;
            running <= (startCount != '0);  // One-cycle run needs no count
            done    <= (startCount == '0);
        end
        else
        begin
            count   <= running ? count - W'(1) : count;
            running <= running && !lastCycle;
            done    <= lastCycle;
        end
    end
endmodule // op_cycle_timer

// *** verilog/fpu_control_transcend_decode.sv ***
// Decoder and sequencer for the transcendental and processor-control
// instruction groups of a floating-point coprocessor.
// Assumes the host presents one escape instruction per instrValid pulse
// and holds further numeric instructions while busy is high.
`include "fpu_decode_cfg.svh"

module fpu_control_transcend_decode (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        instrValid,
    input  wire logic [7:0]  instrByte0,
    input  wire logic [7:0]  instrByte1,
    input  wire logic [31:0] instrAddr,
    input  wire logic [3:0]  prefixCount,
    input  wire logic        protectedMode,
    input  wire logic        slowPath,
    input  wire logic        largeOperand,
    input  wire logic [5:0]  exceptionEvent,
    input  wire logic [15:0] controlWordIn,
    output logic             busy,
    output logic             errorOut,
    output logic             hostStatusValid,
    output logic             memStatusValid,
    output logic [15:0]      statusWord,
    output logic [15:0]      controlWord,
    output logic [2:0]       stackPtr,
    output logic [5:0]       exceptionFlags,
    output logic [31:0]      savedInstrPtr,
    output logic [10:0]      savedOpcode,
    output logic             ptrFormatProtected,
    output logic             unknownOp
);
    fpu_decode_pkg::op_type    decodedOp;
    fpu_decode_pkg::op_type    activeOp;
    fpu_decode_pkg::state_type state;
    logic [9:0] minCycles;
    logic [9:0] maxCycles;
    logic       timerRunning;
    logic       timerDone;

    // Field split of the two instruction bytes
    wire       isEscape   = instrByte0[7:3] == `COPROC_ESCAPE_TAG;
    wire [2:0] group      = instrByte0[2:0];
    wire [2:0] regField   = instrByte1[5:3];
    wire       memForm    = instrByte1[7:6] != `MOD_REGISTER_FORM;
    wire       grp1       = isEscape && group == `GROUP_001;
    wire       grp3       = isEscape && group == `GROUP_011;
    wire       grp5       = isEscape && group == `GROUP_101;
    wire       grp7       = isEscape && group == `GROUP_111;
    wire       isLegacy   = grp3 && (instrByte1 == `BYTE_LEGACY_INT_EN ||
                                     instrByte1 == `BYTE_LEGACY_INT_DIS);
    wire       isTrig     = decodedOp == fpu_decode_pkg::OP_COSINE ||
                            decodedOp == fpu_decode_pkg::OP_PARTIAL_TANGENT ||
                            decodedOp == fpu_decode_pkg::OP_SINE ||
                            decodedOp == fpu_decode_pkg::OP_SINE_COSINE;
    wire       accept     = instrValid && state == fpu_decode_pkg::ST_IDLE &&
                            decodedOp != fpu_decode_pkg::OP_NONE;
    wire [9:0] extraRange = slowPath ? maxCycles - minCycles : 10'h000;
    wire [9:0] extraTrig  = (isTrig && largeOperand) ? `CYC_REDUCTION
                                                     : 10'h000;
    wire [9:0] duration   = minCycles + extraRange + extraTrig;
    wire [31:0] prefixStart = instrAddr - {28'h0000000, prefixCount};
    wire [5:0] unmasked   = exceptionFlags & ~controlWord[5:0];

    // Opcode decode per group and second byte
    always_comb
    begin
        decodedOp = fpu_decode_pkg::OP_NONE;
        if (grp1 && memForm)
        begin
            case (regField)
                `REG_LOAD_CONTROL: decodedOp =
                    fpu_decode_pkg::OP_LOAD_CONTROL_WORD;
                `REG_STORE_ENV:    decodedOp =
                    fpu_decode_pkg::OP_STORE_ENVIRONMENT;
                `REG_LOAD_ENV:     decodedOp =
                    fpu_decode_pkg::OP_LOAD_ENVIRONMENT;
                default:           decodedOp = fpu_decode_pkg::OP_NONE;
            endcase
        end
        else if (grp1)
        begin
            case (instrByte1)
                `BYTE_COSINE:          decodedOp =
                    fpu_decode_pkg::OP_COSINE;
                `BYTE_PART_TANGENT:    decodedOp =
                    fpu_decode_pkg::OP_PARTIAL_TANGENT;
                `BYTE_PART_ARCTANGENT: decodedOp =
                    fpu_decode_pkg::OP_PARTIAL_ARCTANGENT;
                `BYTE_SINE:            decodedOp =
                    fpu_decode_pkg::OP_SINE;
                `BYTE_SINE_COSINE:     decodedOp =
                    fpu_decode_pkg::OP_SINE_COSINE;
                `BYTE_LOG_PLUS_ONE:    decodedOp =
                    fpu_decode_pkg::OP_SCALED_LOG_PLUS_ONE;
                `BYTE_STACK_INC:       decodedOp =
                    fpu_decode_pkg::OP_STACK_PTR_INCREMENT;
                `BYTE_STACK_DEC:       decodedOp =
                    fpu_decode_pkg::OP_STACK_PTR_DECREMENT;
                `BYTE_NO_OPERATION:    decodedOp =
                    fpu_decode_pkg::OP_NO_OPERATION;
                default:               decodedOp = fpu_decode_pkg::OP_NONE;
            endcase
        end
        else if (grp3 && instrByte1 == `BYTE_REINITIALIZE)
            decodedOp = fpu_decode_pkg::OP_REINITIALIZE;
        else if (grp3 && instrByte1 == `BYTE_CLEAR_EXCEPTIONS)
            decodedOp = fpu_decode_pkg::OP_CLEAR_EXCEPTIONS;
        else if (grp7 && instrByte1 == `BYTE_STATUS_TO_HOST)
            decodedOp = fpu_decode_pkg::OP_STORE_STATUS_WORD_HOST;
        else if (grp5 && memForm && regField == `REG_STORE_STATUS)
            decodedOp = fpu_decode_pkg::OP_STORE_STATUS_WORD_MEM;
        else if (grp5 && memForm && regField == `REG_SAVE_STATE)
            decodedOp = fpu_decode_pkg::OP_SAVE_FULL_STATE;
        else if (grp5 && memForm && regField == `REG_RESTORE_STATE)
            decodedOp = fpu_decode_pkg::OP_RESTORE_FULL_STATE;
    end

    // Cycle range of the decoded operation
    always_comb
    begin
        case (decodedOp)
            fpu_decode_pkg::OP_COSINE:
            begin
                minCycles = `CYC_COSINE_MIN;
                maxCycles = `CYC_COSINE_MAX;
            end
            fpu_decode_pkg::OP_PARTIAL_TANGENT:
            begin
                minCycles = `CYC_TANGENT_MIN;
                maxCycles = `CYC_TANGENT_MAX;
            end
            fpu_decode_pkg::OP_PARTIAL_ARCTANGENT:
            begin
                minCycles = `CYC_ARCTAN_MIN;
                maxCycles = `CYC_ARCTAN_MAX;
            end
            fpu_decode_pkg::OP_SINE:
            begin
                minCycles = `CYC_SINE_MIN;
                maxCycles = `CYC_SINE_MAX;
            end
            fpu_decode_pkg::OP_SINE_COSINE:
            begin
                minCycles = `CYC_SINCOS_MIN;
                maxCycles = `CYC_SINCOS_MAX;
            end
            fpu_decode_pkg::OP_SCALED_LOG_PLUS_ONE:
            begin
                minCycles = `CYC_LOGP1_MIN;
                maxCycles = `CYC_LOGP1_MAX;
            end
            fpu_decode_pkg::OP_STORE_ENVIRONMENT:
            begin
                minCycles = `CYC_STORE_ENV_MIN;
                maxCycles = `CYC_STORE_ENV_MAX;
            end
            fpu_decode_pkg::OP_SAVE_FULL_STATE:
            begin
                minCycles = `CYC_SAVE_STATE_MIN;
                maxCycles = `CYC_SAVE_STATE_MAX;
            end
            fpu_decode_pkg::OP_REINITIALIZE:
            begin
                minCycles = `CYC_REINITIALIZE;
                maxCycles = `CYC_REINITIALIZE;
            end
            fpu_decode_pkg::OP_STORE_STATUS_WORD_HOST:
            begin
                minCycles = `CYC_STATUS_TO_HOST;
                maxCycles = `CYC_STATUS_TO_HOST;
            end
            fpu_decode_pkg::OP_LOAD_CONTROL_WORD:
            begin
                minCycles = `CYC_LOAD_CONTROL;
                maxCycles = `CYC_LOAD_CONTROL;
            end
            fpu_decode_pkg::OP_STORE_STATUS_WORD_MEM:
            begin
                minCycles = `CYC_STORE_STATUS;
                maxCycles = `CYC_STORE_STATUS;
            end
            fpu_decode_pkg::OP_CLEAR_EXCEPTIONS:
            begin
                minCycles = `CYC_CLEAR_EXCEPTIONS;
                maxCycles = `CYC_CLEAR_EXCEPTIONS;
            end
            fpu_decode_pkg::OP_LOAD_ENVIRONMENT:
            begin
                minCycles = `CYC_LOAD_ENV;
                maxCycles = `CYC_LOAD_ENV;
            end
            fpu_decode_pkg::OP_RESTORE_FULL_STATE:
            begin
                minCycles = `CYC_RESTORE_STATE;
                maxCycles = `CYC_RESTORE_STATE;
            end
            fpu_decode_pkg::OP_STACK_PTR_INCREMENT:
            begin
                minCycles = `CYC_STACK_INC;
                maxCycles = `CYC_STACK_INC;
            end
            fpu_decode_pkg::OP_STACK_PTR_DECREMENT:
            begin
                minCycles = `CYC_STACK_DEC;
                maxCycles = `CYC_STACK_DEC;
            end
            fpu_decode_pkg::OP_NO_OPERATION:
            begin
                minCycles = `CYC_NO_OPERATION;
                maxCycles = `CYC_NO_OPERATION;
            end
            default:
            begin
                minCycles = 10'h001;
                maxCycles = 10'h001;
            end
        endcase
    end

    // Execution timer, loaded so busy stands exactly duration cycles
    op_cycle_timer #(.W(10)) timer (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .start      (accept),
        .startCount (duration - 10'h001),
        .running    (timerRunning),
        .done       (timerDone)
    );

    // Sequencer and busy line
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state    <= fpu_decode_pkg::ST_IDLE;
            activeOp <= fpu_decode_pkg::OP_NONE;
            busy     <= 1'b0;
        end
        else if (accept)
        begin
            state    <= fpu_decode_pkg::ST_EXECUTE;
            activeOp <= decodedOp;
            busy     <= 1'b1;
        end
        else if (timerDone)
        begin
            state <= fpu_decode_pkg::ST_IDLE;
            busy  <= 1'b0;
        end
    end

    // Saved pointer image and unknown-opcode pulse; legacy opcodes skip all
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            savedInstrPtr      <= 32'h00000000;
            savedOpcode        <= 11'h000;
            ptrFormatProtected <= 1'b0;
            unknownOp          <= 1'b0;
        end
        else
        begin
            unknownOp <= instrValid && !isLegacy && !busy &&
                         decodedOp == fpu_decode_pkg::OP_NONE;
            if (accept)
            begin
                savedInstrPtr      <= prefixStart;
                savedOpcode        <= protectedMode ? 11'h000
                                      : {group, instrByte1};
                ptrFormatProtected <= protectedMode;
            end
        end
    end

    // Completion effects; a new exception beats a clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            controlWord     <= `RESET_CONTROL_WORD;
            stackPtr        <= `RESET_STACK_PTR;
            exceptionFlags  <= `RESET_EXC_FLAGS;
            hostStatusValid <= 1'b0;
            memStatusValid  <= 1'b0;
            statusWord      <= 16'h0000;
            errorOut        <= 1'b0;
        end
        else
        begin
            hostStatusValid <= timerDone &&
                activeOp == fpu_decode_pkg::OP_STORE_STATUS_WORD_HOST;
            memStatusValid  <= timerDone &&
                activeOp == fpu_decode_pkg::OP_STORE_STATUS_WORD_MEM;
            statusWord      <= {2'h0, stackPtr, 3'h0, errorOut, 1'b0,
                                exceptionFlags};
            errorOut        <= |unmasked;
            if (timerDone && activeOp == fpu_decode_pkg::OP_REINITIALIZE)
            begin
                controlWord    <= `RESET_CONTROL_WORD;
                stackPtr       <= `RESET_STACK_PTR;
                exceptionFlags <= exceptionEvent;
            end
            else
            begin
                if (timerDone &&
                    activeOp == fpu_decode_pkg::OP_LOAD_CONTROL_WORD)
                    controlWord <= controlWordIn;
                if (timerDone &&
                    activeOp == fpu_decode_pkg::OP_STACK_PTR_INCREMENT)
                    stackPtr <= stackPtr + 3'h1;
                else if (timerDone &&
                    activeOp == fpu_decode_pkg::OP_STACK_PTR_DECREMENT)
                    stackPtr <= stackPtr - 3'h1;
                if (timerDone &&
                    activeOp == fpu_decode_pkg::OP_CLEAR_EXCEPTIONS)
                    exceptionFlags <= exceptionEvent;
                else
                    exceptionFlags <= exceptionFlags | exceptionEvent;
            end
        end
    end

    // Helper for the length checks: busy cycles and the expected count
    logic [9:0] busyLen;
    logic [9:0] expectLen;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            busyLen   <= 10'h000;
            expectLen <= 10'h000;
        end
        else if (accept)
        begin
            busyLen   <= 10'h000;
            expectLen <= duration;
        end
        else if (busy)
            busyLen <= busyLen + 10'h001;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_reinit_run;
        busy [*8] ##25 busy;
    endsequence

    a_escape_accept: assert property (accept |-> isEscape ##1 busy)
        else $error("accepted op without escape or busy");
    a_busy_length: assert property ($fell(busy) |-> busyLen == expectLen)
        else $error("busy length differs from decoded cycle count");
    a_cosine_fast: assert property (accept && !slowPath && !largeOperand &&
        decodedOp == fpu_decode_pkg::OP_COSINE |-> ##123 busy ##1 !busy)
        else $error("cosine fast path not 123 cycles");
    a_reinit_time: assert property (accept &&
        decodedOp == fpu_decode_pkg::OP_REINITIALIZE
        |=> s_reinit_run ##1 !busy)
        else $error("reinitialize not 33 cycles");
    a_clear_time: assert property (accept &&
        decodedOp == fpu_decode_pkg::OP_CLEAR_EXCEPTIONS
        |-> ##11 busy ##1 !busy)
        else $error("clear exceptions not 11 cycles");
    a_status_host: assert property (accept &&
        decodedOp == fpu_decode_pkg::OP_STORE_STATUS_WORD_HOST
        |-> ##14 hostStatusValid)
        else $error("status word not delivered after 13 cycles");
    a_stack_increment: assert property (accept &&
        decodedOp == fpu_decode_pkg::OP_STACK_PTR_INCREMENT
        |-> ##22 stackPtr == 3'($past(stackPtr, 22) + 3'h1))
        else $error("stack pointer increment wrong");
    a_legacy_ignored: assert property (instrValid && isLegacy && !busy
        |=> !busy && $stable(stackPtr) && $stable(controlWord)
            && !unknownOp)
        else $error("legacy opcode changed state");
    a_error_direct: assert property ((|(exceptionEvent & ~controlWord[5:0]))
        |-> ##2 errorOut)
        else $error("unmasked exception not on error output");
    a_saved_pointer: assert property (accept |=> savedInstrPtr ==
        $past(instrAddr) - {28'h0000000, $past(prefixCount)})
        else $error("saved pointer not at first prefix");
    a_protected_image: assert property (accept && protectedMode
        |=> savedOpcode == 11'h000 && ptrFormatProtected)
        else $error("protected image holds an opcode");
endmodule // fpu_control_transcend_decode

// *** dv/host_model.sv ***
// Host side model: issues one escape instruction per go pulse.
// Assumes the decoder's busy level and one shared clock.
module host_model (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       busy,
    input  wire logic       go,
    input  wire logic [7:0] opA,
    input  wire logic [7:0] opB,
    output logic            instrValid,
    output logic [7:0]      instrByte0,
    output logic [7:0]      instrByte1
);
    timeunit 1ns;
    timeprecision 1ns;
    wire issue = go && !busy && !reset;
    // Bytes toggle while no instruction is offered
    always_ff @(posedge sys_clk)
    begin
        instrValid <= issue;
        instrByte0 <= issue ? opA : (reset ? 8'h00 : ~instrByte0);
        instrByte1 <= issue ? opB : (reset ? 8'h00 : ~instrByte1);
    end
endmodule // host_model

// *** dv/fpu_control_transcend_decode_bench.sv ***
// Self-checking bench of the control and transcendental decoder.
// Assumes the host model and the design files are compiled first.
module fpu_control_transcend_decode_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, reset = 1'b1, go = 1'b0, protectedMode = 1'b0;
    logic slowPath = 1'b0, largeOperand = 1'b0, instrValid, busy, errorOut;
    logic hostStatusValid, memStatusValid, ptrFormatProtected, unknownOp;
    logic [7:0] opA = 8'h00, opB = 8'h00, instrByte0, instrByte1;
    logic [5:0] exceptionEvent = 6'h00, exceptionFlags;
    logic [15:0] statusWord, controlWord;
    logic [2:0] stackPtr;
    logic [31:0] savedInstrPtr;
    logic [10:0] savedOpcode;
    logic hv, mv, uk;
    int n_fail = 0, n_tests = 0, cnt;
    localparam logic [10:0] OPS [18] = '{11'h1ff, 11'h1f2, 11'h1fe,
        11'h1fb, 11'h1f3, 11'h1f9, 11'h3e3, 11'h7e0, 11'h3e2, 11'h130,
        11'h120, 11'h530, 11'h520, 11'h1f7, 11'h1f6, 11'h1d0, 11'h538,
        11'h128};
    localparam int LO [18] = '{123, 191, 122, 194, 314, 257, 33, 13, 11,
        103, 71, 375, 308, 21, 22, 12, 15, 19};
    localparam int HI [18] = '{772, 497, 771, 809, 487, 547, 33, 13, 11,
        104, 71, 376, 308, 21, 22, 12, 15, 19};
    always #25 sys_clk = ~sys_clk;
    host_model host (.sys_clk, .reset, .busy, .go, .opA, .opB, .instrValid,
        .instrByte0, .instrByte1);
    fpu_control_transcend_decode dut (.sys_clk, .reset, .instrValid,
        .instrByte0, .instrByte1, .instrAddr(32'h0000_1000),
        .prefixCount(4'h3), .protectedMode, .slowPath, .largeOperand,
        .exceptionEvent, .controlWordIn(16'h0000), .busy, .errorOut,
        .hostStatusValid, .memStatusValid, .statusWord, .controlWord,
        .stackPtr, .exceptionFlags, .savedInstrPtr, .savedOpcode,
        .ptrFormatProtected, .unknownOp);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Issue one instruction, then count busy cycles
    task run(input logic [7:0] a, input logic [7:0] b, input logic s, l);
        @(posedge sys_clk);
        go <= 1'b1;
        opA <= a;
        opB <= b;
        slowPath <= s;
        largeOperand <= l;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        #1 uk = unknownOp;
        for (cnt = 0; busy === 1'b1 && cnt < 2000; cnt++)
            @(posedge sys_clk) #1;
        hv = hostStatusValid;
        mv = memStatusValid;
    endtask
    task test_timing;
        for (int k = 0; k < 18; k++)
        begin
            run({5'h1b, OPS[k][10:8]}, OPS[k][7:0], 1'b0, 1'b0);
            chk(cnt, LO[k]);
            chk(hv, k == 7);
            chk(mv, k == 16);
            run({5'h1b, OPS[k][10:8]}, OPS[k][7:0], 1'b1, 1'b1);
            chk(cnt, HI[k] + ((k < 4) ? 76 : 0));
            if (k == 13)
                chk(stackPtr, 3'h2);
        end
        chk(controlWord, 16'h0000);
        chk(savedInstrPtr, 32'h0000_0ffd);
        $display("timing test done");
    endtask
    task test_exceptions;
        @(posedge sys_clk) exceptionEvent <= 6'h04;
        @(posedge sys_clk) exceptionEvent <= 6'h00;
        repeat (3) @(posedge sys_clk);
        #1 chk(exceptionFlags, 6'h04);
        chk(errorOut, 1'b1);
        chk(statusWord, 16'h0084);
        run(8'hdb, 8'he2, 1'b0, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1 chk(exceptionFlags, 6'h00);
        chk(errorOut, 1'b0);
        $display("exception test done");
    endtask
    task test_refused;
        for (int j = 0; j < 2; j++)
        begin
            run(8'hdb, j ? 8'he1 : 8'he0, 1'b0, 1'b0);
            chk(cnt, 0);
            chk(uk, 1'b0);
            chk(savedOpcode, 11'h3e2);
        end
        run(8'h19, 8'hff, 1'b0, 1'b0);
        chk(cnt, 0);
        chk(uk, 1'b1);
        $display("refusal test done");
    endtask
    task test_protected;
        @(posedge sys_clk) protectedMode <= 1'b1;
        run(8'hd9, 8'hd0, 1'b0, 1'b0);
        chk({ptrFormatProtected, savedOpcode}, 12'h800);
        chk(savedInstrPtr, 32'h0000_0ffd);
        $display("protected test done");
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence after an eight cycle reset
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        test_timing;
        test_exceptions;
        test_refused;
        test_protected;
        complete_run;
    end
    // Watchdog against a hung handshake
    initial
    begin
        #(20000 * 50);
        n_fail++;
        complete_run;
    end
endmodule // fpu_control_transcend_decode_bench
